// File: logic/dtc_timer.sv
// Dual timer control and mode block with AHB-Lite register slave
//
// Overview of operation
// - Timer one overflow sets flag, except in split mode; vector clears
// - Timer zero overflow sets flag; vector clears
// - Timer one counts only when run set, except in split mode
// - Gate one needs run and active irq one
// - Timer zero counts only when run set
// - Gate zero needs run and active irq zero
// - Timer one: internal tick or pin falls
// - Timer zero: internal tick or pin falls
// - Timer one modes: 13,16,reload,inactive
// - Timer zero modes: 13,16,reload,split
// - Irq one flag set by edge/level
// - Irq zero flag set by edge/level
// - Irq one type: level zero, edge one
// - Irq zero type: level zero, edge one
// - Control at 0x88, mode 0x89, reset zero
// - 13-bit count wraps 0x1FFF, sets flag
// - Reload mode: low counts, high reloads it
// - Split high byte uses timer one run/flag
// - Run bit never clears or reloads count
`timescale 1ns/100ps
`include "dtc_map.svh"

module dtc_timer
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Internal tick and interrupt vector acknowledges
  input wire logic tick_en,
  input wire logic [3:0] vector_ack,
  // Pins
  input wire logic t_zero_count_pin,
  input wire logic t_one_count_pin,
  input wire logic ext_irq_zero_input,
  input wire logic ext_irq_one_input,
  // Status outputs
  output logic t_zero_overflow_flag,
  output logic t_one_overflow_flag,
  output logic ext_irq_zero_flag,
  output logic ext_irq_one_flag
);

  dtc_state_t s_q;
  dtc_state_t s_d;

  function automatic logic [7:0] dtc_inc8(input logic [7:0] v);
    dtc_inc8 = v + 8'h01;
  endfunction

  function automatic logic [7:0] dtc_rd(input dtc_state_t s,
                                        input logic [7:0] a);
    if (a == `DTC_OFS_CTRL) begin
      dtc_rd = s.ctrl;
    end else if (a == `DTC_OFS_MODE) begin
      dtc_rd = s.mode;
    end else if (a == `DTC_OFS_T0_LOW) begin
      dtc_rd = s.t0_lo;
    end else if (a == `DTC_OFS_T1_LOW) begin
      dtc_rd = s.t1_lo;
    end else if (a == `DTC_OFS_T0_HIGH) begin
      dtc_rd = s.t0_hi;
    end else if (a == `DTC_OFS_T1_HIGH) begin
      dtc_rd = s.t1_hi;
    end else if (a == `DTC_OFS_VECTOR) begin
      dtc_rd = {2'b00, s.pol, 4'h0};
    end else begin
      dtc_rd = 8'h00;
    end
  endfunction

  always_comb begin
    logic wr;
    logic [7:0] wd;
    logic [1:0] act;
    logic [1:0] cnt_fall;
    logic [1:0] irq_fall;
    logic [1:0] irq_rise;
    logic [1:0] irq_edge;
    logic [1:0] en;
    logic [1:0] inc;
    logic split;
    logic [1:0] m0;
    logic [1:0] m1;
    logic ov0;
    logic ov1;
    logic [7:0] nlo;
    logic [7:0] nhi;
    wr = 1'b0;
    wd = 8'h00;
    act = 2'b00;
    cnt_fall = 2'b00;
    irq_fall = 2'b00;
    irq_rise = 2'b00;
    irq_edge = 2'b00;
    en = 2'b00;
    inc = 2'b00;
    split = 1'b0;
    m0 = 2'b00;
    m1 = 2'b00;
    ov0 = 1'b0;
    ov1 = 1'b0;
    nlo = 8'h00;
    nhi = 8'h00;
    s_d = s_q;
    // Pin synchronisers and edge detection
    s_d.cnt_s1 = {t_one_count_pin, t_zero_count_pin};
    s_d.cnt_s2 = s_q.cnt_s1;
    s_d.cnt_s3 = s_q.cnt_s2;
    s_d.irq_s1 = {ext_irq_one_input, ext_irq_zero_input};
    s_d.irq_s2 = s_q.irq_s1;
    s_d.irq_s3 = s_q.irq_s2;
    cnt_fall = s_q.cnt_s3 & ~s_q.cnt_s2;
    irq_fall = s_q.irq_s3 & ~s_q.irq_s2;
    irq_rise = ~s_q.irq_s3 & s_q.irq_s2;
    // Active level per polarity: polarity 0 is active low
    act = s_q.irq_s2 ~^ s_q.pol;
    irq_edge = (irq_rise & s_q.pol) | (irq_fall & ~s_q.pol);
    // AHB data phase write
    wr = s_q.ahb_act & s_q.ahb_write;
    wd = hwdata[7:0];
    s_d.hready = 1'b1;
    s_d.hrdata = 32'h0000_0000;
    if (wr) begin
      if (s_q.ahb_addr == `DTC_OFS_CTRL) begin
        s_d.ctrl = wd;
      end else if (s_q.ahb_addr == `DTC_OFS_MODE) begin
        s_d.mode = wd;
      end else if (s_q.ahb_addr == `DTC_OFS_T0_LOW) begin
        s_d.t0_lo = wd;
      end else if (s_q.ahb_addr == `DTC_OFS_T1_LOW) begin
        s_d.t1_lo = wd;
      end else if (s_q.ahb_addr == `DTC_OFS_T0_HIGH) begin
        s_d.t0_hi = wd;
      end else if (s_q.ahb_addr == `DTC_OFS_T1_HIGH) begin
        s_d.t1_hi = wd;
      end else if (s_q.ahb_addr == `DTC_OFS_VECTOR) begin
        s_d.pol = wd[`DTC_BIT_POL1:`DTC_BIT_POL0];
      end
    end
    // Address phase capture and read data
    s_d.ahb_act = hsel & hready & htrans[1];
    s_d.ahb_write = hwrite;
    s_d.ahb_addr = haddr[9:2];
    if (hsel & hready & htrans[1] & ~hwrite) begin
      s_d.hrdata = {24'h000000, dtc_rd(s_d, haddr[9:2])};
    end
    // Run enables and gating
    m0 = s_q.mode[1:0];
    m1 = s_q.mode[5:4];
    split = (m0 == DTC_MODE_SPLIT);
    en[0] = s_q.ctrl[`DTC_BIT_TR0] &
      (~s_q.mode[`DTC_BIT_T_ZERO_GATE_ENABLE] | act[0]);
    en[1] = s_q.ctrl[`DTC_BIT_TR1] &
      (~s_q.mode[`DTC_BIT_T_ONE_GATE_ENABLE] | act[1]);
    inc[0] = en[0] & (s_q.mode[`DTC_BIT_CT0] ? cnt_fall[0] : tick_en);
    inc[1] = en[1] & (s_q.mode[`DTC_BIT_CT1] ? cnt_fall[1] : tick_en);
    // Timer one stays inactive in mode 3; in split mode its run bit
    // moves to timer zero high byte and its pin is ignored
    if (split) begin
      inc[1] = tick_en & ~s_q.mode[`DTC_BIT_CT1] & (m1 != DTC_MODE_SPLIT);
    end
    // Timer zero (counting never resets the value on run set)
    nlo = dtc_inc8(s_q.t0_lo);
    nhi = dtc_inc8(s_q.t0_hi);
    if (inc[0]) begin
      case (m0)
        DTC_MODE_13: begin
          s_d.t0_lo = {3'b000, nlo[4:0]};
          if (s_q.t0_lo[4:0] == 5'h1F) begin
            s_d.t0_hi = nhi;
            ov0 = (s_q.t0_hi == 8'hFF);
          end
        end
        DTC_MODE_16: begin
          s_d.t0_lo = nlo;
          if (s_q.t0_lo == 8'hFF) begin
            s_d.t0_hi = nhi;
            ov0 = (s_q.t0_hi == 8'hFF);
          end
        end
        DTC_MODE_RELOAD: begin
          s_d.t0_lo = (s_q.t0_lo == 8'hFF) ? s_q.t0_hi : nlo;
          ov0 = (s_q.t0_lo == 8'hFF);
        end
        default: begin
          s_d.t0_lo = nlo;
          ov0 = (s_q.t0_lo == 8'hFF);
        end
      endcase
    end
    // Split high byte: internal tick, timer one run bit
    if (split & tick_en & s_q.ctrl[`DTC_BIT_TR1]) begin
      s_d.t0_hi = nhi;
      ov1 = (s_q.t0_hi == 8'hFF);
    end
    // Timer one
    nlo = dtc_inc8(s_q.t1_lo);
    nhi = dtc_inc8(s_q.t1_hi);
    if (inc[1]) begin
      case (m1)
        DTC_MODE_13: begin
          s_d.t1_lo = {3'b000, nlo[4:0]};
          if (s_q.t1_lo[4:0] == 5'h1F) begin
            s_d.t1_hi = nhi;
            ov1 = ov1 | (~split & (s_q.t1_hi == 8'hFF));
          end
        end
        DTC_MODE_16: begin
          s_d.t1_lo = nlo;
          if (s_q.t1_lo == 8'hFF) begin
            s_d.t1_hi = nhi;
            ov1 = ov1 | (~split & (s_q.t1_hi == 8'hFF));
          end
        end
        DTC_MODE_RELOAD: begin
          s_d.t1_lo = (s_q.t1_lo == 8'hFF) ? s_q.t1_hi : nlo;
          ov1 = ov1 | (~split & (s_q.t1_lo == 8'hFF));
        end
        default: begin
          s_d.t1_lo = s_q.t1_lo;
        end
      endcase
    end
    // Timer flags, and irq flags in edge mode, clear by interrupt vector, then hardware sets win
    if (vector_ack[`DTC_VEC_T1]) s_d.ctrl[`DTC_BIT_TF1] = 1'b0;
    if (vector_ack[`DTC_VEC_T0]) s_d.ctrl[`DTC_BIT_TF0] = 1'b0;
    if (vector_ack[`DTC_VEC_EXT1] & s_q.ctrl[`DTC_BIT_IT1]) begin
      s_d.ctrl[`DTC_BIT_IE1] = 1'b0;
    end
    if (vector_ack[`DTC_VEC_EXT0] & s_q.ctrl[`DTC_BIT_IT0]) begin
      s_d.ctrl[`DTC_BIT_IE0] = 1'b0;
    end
    if (ov1) s_d.ctrl[`DTC_BIT_TF1] = 1'b1;
    if (ov0) s_d.ctrl[`DTC_BIT_TF0] = 1'b1;
    if (s_q.ctrl[`DTC_BIT_IT1] ? irq_edge[1] : act[1]) begin
      s_d.ctrl[`DTC_BIT_IE1] = 1'b1;
    end
    if (s_q.ctrl[`DTC_BIT_IT0] ? irq_edge[0] : act[0]) begin
      s_d.ctrl[`DTC_BIT_IE0] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.hready <= 1'b1;
      // Synchronisers start at the idle high pin level so that no
      // false edge or active level is seen right after reset
      s_q.cnt_s1 <= 2'b11;
      s_q.cnt_s2 <= 2'b11;
      s_q.cnt_s3 <= 2'b11;
      s_q.irq_s1 <= 2'b11;
      s_q.irq_s2 <= 2'b11;
      s_q.irq_s3 <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops, hresp tied to zero
  assign hreadyout = s_q.hready;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign t_zero_overflow_flag = s_q.ctrl[`DTC_BIT_TF0];
  assign t_one_overflow_flag = s_q.ctrl[`DTC_BIT_TF1];
  assign ext_irq_zero_flag = s_q.ctrl[`DTC_BIT_IE0];
  assign ext_irq_one_flag = s_q.ctrl[`DTC_BIT_IE1];

endmodule

// File: logic/dtc_map.svh
// Register offsets, field positions and reset values of the dual timer block
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_OFS_CTRL 8'h88
`define DTC_OFS_MODE 8'h89
`define DTC_OFS_T0_LOW 8'h8A
`define DTC_OFS_T1_LOW 8'h8B
`define DTC_OFS_T0_HIGH 8'h8C
`define DTC_OFS_T1_HIGH 8'h8D
`define DTC_OFS_VECTOR 8'h90
`define DTC_BIT_TF1 7
`define DTC_BIT_TR1 6
`define DTC_BIT_TF0 5
`define DTC_BIT_TR0 4
`define DTC_BIT_IE1 3
`define DTC_BIT_IT1 2
`define DTC_BIT_IE0 1
`define DTC_BIT_IT0 0
`define DTC_BIT_T_ONE_GATE_ENABLE 7
`define DTC_BIT_CT1 6
`define DTC_BIT_T_ZERO_GATE_ENABLE 3
`define DTC_BIT_CT0 2
`define DTC_VEC_EXT0 0
`define DTC_VEC_T0 1
`define DTC_VEC_EXT1 2
`define DTC_VEC_T1 3
`define DTC_BIT_POL0 4
`define DTC_BIT_POL1 5
`define DTC_RST_BYTE 8'h00
`endif

// File: logic/dtc_pkg.sv
// Types of the dual timer block
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'b00,
    DTC_MODE_16 = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_t;

  typedef struct packed {
    logic ahb_act;
    logic ahb_write;
    logic [7:0] ahb_addr;
    logic hready;
    logic [31:0] hrdata;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [1:0] pol;
    logic [7:0] t0_lo;
    logic [7:0] t0_hi;
    logic [7:0] t1_lo;
    logic [7:0] t1_hi;
    logic [1:0] cnt_s1;
    logic [1:0] cnt_s2;
    logic [1:0] cnt_s3;
    logic [1:0] irq_s1;
    logic [1:0] irq_s2;
    logic [1:0] irq_s3;
  } dtc_state_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } dtc_ahb_req_t;
endpackage

// File: tb/dtc_timer_asserts.sv
// Port checks for the dual timer block
`timescale 1ns/100ps
module dtc_timer_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bus and acknowledges
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [3:0] vector_ack,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Flags
  input wire logic t_zero_overflow_flag,
  input wire logic t_one_overflow_flag,
  input wire logic ext_irq_zero_flag,
  input wire logic ext_irq_one_flag
);
  logic [3:0] flg;
  logic wr, rd;
  assign flg = {t_one_overflow_flag, ext_irq_one_flag,
    t_zero_overflow_flag, ext_irq_zero_flag};
  assign wr = hsel && hready && htrans[1] && hwrite;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bad response");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("wait state");
  a_reset_clear: assert property ($fell(sys_rst) |-> flg == 4'h0)
    else $error("flags after reset");
  a_rdata_idle: assert property (!$past(rd) |-> hrdata == 32'h0)
    else $error("stray read data");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data");
  a_e0_flag_fall: assert property ($fell(flg[0]) |->
    $past(vector_ack[0]) || $past(wr, 2)) else $error("e0 flag fell");
  a_t0_flag_fall: assert property ($fell(flg[1]) |->
    $past(vector_ack[1]) || $past(wr, 2)) else $error("t0 flag fell");
  a_e1_flag_fall: assert property ($fell(flg[2]) |->
    $past(vector_ack[2]) || $past(wr, 2)) else $error("e1 flag fell");
  a_t1_flag_fall: assert property ($fell(flg[3]) |->
    $past(vector_ack[3]) || $past(wr, 2)) else $error("t1 flag fell");
endmodule
bind dtc_timer dtc_timer_asserts i_chk (.core_clk, .sys_rst, .hsel,
  .htrans, .hwrite, .hready, .vector_ack, .hreadyout, .hresp, .hrdata,
  .t_zero_overflow_flag, .t_one_overflow_flag, .ext_irq_zero_flag,
  .ext_irq_one_flag);

// File: tb/dtc_pins.sv
// Model of the count and gate pins outside the timer block
`timescale 1ns/100ps
module dtc_pins (
  // Clock
  input wire logic core_clk,
  // Pins
  output logic [1:0] cnt_pin,
  output logic [1:0] irq_pin
);
  initial cnt_pin = 2'h3;
  initial irq_pin = 2'h3;
  // One falling edge, each level held past the synchroniser
  task automatic fall(input int t);
    cnt_pin[t] <= 1'b0;
    repeat (4) @(posedge core_clk);
    cnt_pin[t] <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic gate(input int t, input logic v);
    irq_pin[t] <= v;
    repeat (5) @(posedge core_clk);
  endtask
endmodule

// File: tb/dtc_timer_bench.sv
// Self-checking bench for the dual timer block
`timescale 1ns/100ps
`include "dtc_map.svh"
module dtc_timer_bench;
  logic core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic tick_en = 1'b0, hreadyout, hresp, t0f, t1f, e0f, e1f;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, cnt_pin, irq_pin;
  logic [2:0] hsize = 3'h0;
  logic [3:0] vector_ack = 4'h0, flg;
  logic [7:0] la, ha;
  int mismatches = 0;
  int tests_run = 0;
  always #2 core_clk = ~core_clk;
  assign flg = {t1f, e1f, t0f, e0f};
  dtc_pins i_pins (.core_clk, .cnt_pin, .irq_pin);
  dtc_timer i_dut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata,
    .tick_en, .vector_ack, .t_zero_count_pin(cnt_pin[0]),
    .t_one_count_pin(cnt_pin[1]), .ext_irq_zero_input(irq_pin[0]),
    .ext_irq_one_input(irq_pin[1]), .t_zero_overflow_flag(t0f),
    .t_one_overflow_flag(t1f), .ext_irq_zero_flag(e0f),
    .ext_irq_one_flag(e1f));
  task automatic results;
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // Sample mid-cycle what the next rising edge will see
  task automatic wt(output logic [31:0] r);
    logic k;
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      k = hreadyout;
      r = hrdata;
      @(posedge core_clk);
      n++;
    end while (k !== 1'b1 && n < 64);
    if (k !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask
  task automatic bus(input logic [7:0] o, input logic w, input logic [7:0] d,
      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {22'h0, o, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wt(r);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt(r);
  endtask
  task automatic wr(input logic [7:0] o, d);
    logic [31:0] r;
    bus(o, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] o, e, m = 8'hFF);
    logic [31:0] r;
    bus(o, 1'b0, 8'h00, r);
    cmp($sformatf("reg %h", o), {24'h0, e & m}, r & {24'hFFFFFF, m});
  endtask
  task automatic chkf(input int v, input logic e);
    @(negedge core_clk);
    cmp($sformatf("flag %0d", v), {31'h0, e}, {31'h0, flg[v]});
    @(posedge core_clk);
  endtask
  task automatic ticks(input int n);
    tick_en <= 1'b1;
    repeat (n) @(posedge core_clk);
    tick_en <= 1'b0;
  endtask
  task automatic vec(input int v);
    vector_ack[v] <= 1'b1;
    @(posedge core_clk);
    vector_ack[v] <= 1'b0;
    chkf(v, 1'b0);
  endtask
  // One count case: preload, run, tick, then check count and flag
  task automatic tc(input int t, input logic [1:0] md,
      input logic [7:0] lo, hi, input int n, input logic [7:0] el, eh,
      input logic ef);
    wr(`DTC_OFS_CTRL, 8'h00);
    wr(`DTC_OFS_MODE, t ? {2'h0, md, 4'h0} : {6'h0, md});
    wr(la, lo);
    wr(ha, hi);
    wr(`DTC_OFS_CTRL, t ? 8'h40 : 8'h10);
    rd(la, lo);
    ticks(n);
    rd(la, el, md == 2'h0 ? 8'h1F : 8'hFF);
    rd(ha, eh);
    chkf(2 * t + 1, ef);
    vec(2 * t + 1);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(`DTC_OFS_CTRL, 8'h00);
    rd(`DTC_OFS_MODE, 8'h00);
    rd(8'hFF, 8'h00);
    wr(`DTC_OFS_MODE, 8'h5A);
    rd(`DTC_OFS_MODE, 8'h5A);
    for (int t = 0; t < 2; t++) begin
      la = `DTC_OFS_T0_LOW + 8'(t);
      ha = `DTC_OFS_T0_HIGH + 8'(t);
      tc(t, 2'h0, 8'h1F, 8'hFF, 1, 8'h00, 8'h00, 1'b1);
      tc(t, 2'h0, 8'h1F, 8'h00, 1, 8'h00, 8'h01, 1'b0);
      tc(t, 2'h1, 8'hFF, 8'hFF, 1, 8'h00, 8'h00, 1'b1);
      tc(t, 2'h1, 8'h1F, 8'h00, 1, 8'h20, 8'h00, 1'b0);
      tc(t, 2'h2, 8'hFE, 8'hA5, 2, 8'hA5, 8'hA5, 1'b1);
      wr(`DTC_OFS_VECTOR, 8'h30);
      wr(`DTC_OFS_MODE, t ? 8'h90 : 8'h09);
      wr(la, 8'h00);
      i_pins.gate(t, 1'b0);
      ticks(2);
      rd(la, 8'h00);
      i_pins.gate(t, 1'b1);
      ticks(2);
      rd(la, 8'h02);
      wr(`DTC_OFS_VECTOR, 8'h00);
      wr(`DTC_OFS_MODE, t ? 8'h50 : 8'h05);
      tick_en <= 1'b1;
      repeat (3) i_pins.fall(t);
      tick_en <= 1'b0;
      rd(la, 8'h05);
      wr(`DTC_OFS_CTRL, 8'h05);
      i_pins.gate(t, 1'b0);
      chkf(2 * t, 1'b1);
      vec(2 * t);
      wr(`DTC_OFS_CTRL, 8'h00);
      @(posedge core_clk);
      chkf(2 * t, 1'b1);
      i_pins.gate(t, 1'b1);
      wr(`DTC_OFS_CTRL, 8'h00);
      chkf(2 * t, 1'b0);
    end
    wr(`DTC_OFS_MODE, 8'h33);
    wr(`DTC_OFS_T0_HIGH, 8'hFF);
    wr(`DTC_OFS_T1_LOW, 8'h10);
    wr(`DTC_OFS_CTRL, 8'h40);
    ticks(1);
    chkf(3, 1'b1);
    rd(`DTC_OFS_T0_HIGH, 8'h00);
    rd(`DTC_OFS_T1_LOW, 8'h10);
    vec(3);
    results();
  end
endmodule
